// [core/swb_cfg.svh]
// offsets, field positions, codes and timing for the single-wire bridge
`ifndef SWB_CFG_SVH
`define SWB_CFG_SVH
`define SWB_CLK_MHZ 125
`define SWB_TICK_NS 1000
`define SWB_TICK_CYC (`SWB_TICK_NS * `SWB_CLK_MHZ / 1000)
`define SWB_START_MAX_PS 262500
`define SWB_START_MAX_CYC (`SWB_START_MAX_PS * `SWB_CLK_MHZ / 1000000)
`define SWB_I2C_ADDR 7'h18
`define SWB_CMD_RESET 8'hb4
`define SWB_CMD_SLOT 8'h87
`define SWB_PTR_STATUS 8'hf0
`define SWB_SLOT_VBIT 7
// register offsets
`define SWB_A_CFG 4'h0
`define SWB_A_STAT 4'h1
`define SWB_A_ISTAT 4'h2
`define SWB_A_IMASK 4'h3
`define SWB_A_PTR 4'h4
// config bits
`define SWB_C_APU 0
`define SWB_C_SPU 2
`define SWB_C_ODS 3
// status bits
`define SWB_S_BUSY 0
`define SWB_S_PPD 1
`define SWB_S_SD 2
`define SWB_S_SBR 3
// interrupt bits
`define SWB_I_DONE 0
`define SWB_I_PPD 1
`define SWB_I_SD 2
`define SWB_I_REJ 3
// line timing in 1 us ticks, standard then overdrive
`define SWB_RSTL_STD 12'd600
`define SWB_RSTL_OVD 12'd72
`define SWB_RSTH_STD 12'd580
`define SWB_RSTH_OVD 12'd74
`define SWB_SI_STD 12'd8
`define SWB_SI_OVD 12'd2
`define SWB_MSP_STD 12'd70
`define SWB_MSP_OVD 12'd10
`define SWB_SLOT_STD 12'd70
`define SWB_SLOT_OVD 12'd10
`define SWB_W0L_STD 12'd60
`define SWB_W0L_OVD 12'd8
`define SWB_W1L_STD 12'd8
`define SWB_W1L_OVD 12'd1
`define SWB_MSR_STD 12'd15
`define SWB_MSR_OVD 12'd2
`endif

// [core/swb_pkg.sv]
// types shared by the single-wire bridge
package swb_pkg;
  typedef enum logic [2:0] {
    I_IDLE = 3'h0,
    I_ADDR = 3'h1,
    I_CMD = 3'h3,
    I_PARM = 3'h2,
    I_IGN = 3'h6
  } swb_i2c_t;
  typedef enum logic [2:0] {
    W_IDLE = 3'h0,
    W_RLOW = 3'h1,
    W_RHIGH = 3'h3,
    W_SLOW = 3'h2,
    W_SREC = 3'h6
  } swb_wire_t;
endpackage

// [core/swb_sync.sv]
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module swb_sync #(
  parameter int W = 3
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      // every pin idles high, so reset to that level and no false edge follows
      meta_q <= '1;
      dout <= '1;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

// [core/swb_tick.sv]
// 1 us enable pulse, restartable so a command starts on a fresh phase
`timescale 1ns/1ns
`include "swb_cfg.svh"
module swb_tick (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clr,
  output logic tick
);
  localparam logic [7:0] LAST = 8'(`SWB_TICK_CYC - 1);
  logic [7:0] cnt_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 8'h00;
    end else if (clr || cnt_q == LAST) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  assign tick = !clr && cnt_q == LAST;
endmodule

// [core/swb_top.sv]
// i2c command sequencer driving the single-wire line
//
// What this block does
// R1: code b4 with no parameter runs a reset/presence cycle at configured speed
// R2: reset code arriving while line busy is not acknowledged and is dropped
// R3: reset line activity starts within 262.5 ns of the ack falling edge
// R4: reset lasts low plus high time; busy flag high for exactly that
// R5: short and presence sampled after low phase, flags updated at those instants
// R6: accepted reset moves the read pointer to the status register
// R7: slot command is 87 plus one byte; only bit 7 counts
// R8: value 0 gives a write-zero slot, 1 a write-one/read slot
// R9: line level at the read sample point goes into the bit result flag
// R10: slot code arriving while busy: code and byte both unacknowledged, ignored
// R11: slot activity starts within 262.5 ns of the parameter msb falling edge
// R12: slot finishes in one bit cell; busy high for one bit cell
// R13: after a slot command the read pointer selects the status register
// R14: slot honours speed, active pullup and strong pullup settings
// R15: host polls busy until clear before next command or reading results
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "swb_cfg.svh"
module swb_top
  import swb_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic ow_in,
  output logic ow_out,
  output logic ow_oe,
  output logic ow_apu,
  output logic ow_spu,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq
);
  // sync plus edge detect spend 4 of the 32 cycles allowed before the line moves

  // picks the standard or overdrive figure
  function automatic logic [11:0] spd(input logic od,
                                      input logic [11:0] s,
                                      input logic [11:0] o);
    spd = od ? o : s;
  endfunction

  logic [2:0] pins_s;
  logic scl_s, sda_s, ow_s, scl_p_q, sda_p_q;
  logic scl_rise, scl_fall, i2c_start, i2c_stop;
  logic tick, go_rst, go_slot, rej_ev;
  swb_i2c_t i_q, nxt_q;
  swb_wire_t w_q;
  logic [7:0] shf_q, ptr_q;
  logic [3:0] bcnt_q;
  logic ack_ph_q, pend_rst_q, v_q;
  logic [11:0] t_q;
  logic busy_q, ppd_q, sd_q, sbr_q;
  logic [3:0] cfg_q, ist_q, imask_q, ev;
  logic ev_si, ev_msp, ev_msr, rst_end, slot_end, low_end;

  swb_sync #(.W(3)) u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .din({ow_in, sda_in, scl_in}),
    .dout(pins_s)
  );
  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign ow_s = pins_s[2];

  swb_tick u_tick (
    .mclk(mclk),
    .nrst(nrst),
    .clr(go_rst || go_slot),
    .tick(tick)
  );

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end
  assign scl_rise = scl_s && !scl_p_q;
  assign scl_fall = !scl_s && scl_p_q;
  assign i2c_start = scl_s && scl_p_q && !sda_s && sda_p_q;
  assign i2c_stop = scl_s && scl_p_q && sda_s && !sda_p_q;

  // launches fire on the synchronised scl fall, a few cycles after the pin
  assign go_rst = scl_fall && ack_ph_q && pend_rst_q; // R3
  assign go_slot = scl_fall && !ack_ph_q && i_q == I_PARM
                   && bcnt_q == 4'h1; // R11

  // i2c write receiver: address, command code, optional parameter
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      i_q <= I_IDLE;
      nxt_q <= I_IDLE;
      shf_q <= 8'h00;
      bcnt_q <= 4'h0;
      ack_ph_q <= 1'b0;
      pend_rst_q <= 1'b0;
      v_q <= 1'b0;
      sda_oe <= 1'b0;
    end else if (i2c_start) begin
      i_q <= I_ADDR;
      bcnt_q <= 4'h0;
      ack_ph_q <= 1'b0;
      pend_rst_q <= 1'b0;
      sda_oe <= 1'b0;
    end else if (i2c_stop) begin
      i_q <= I_IDLE;
      ack_ph_q <= 1'b0;
      pend_rst_q <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      case (i_q)
        I_IDLE, I_IGN: begin
          sda_oe <= 1'b0;
        end
        I_ADDR, I_CMD, I_PARM: begin
          if (scl_rise && !ack_ph_q) begin
            shf_q <= {shf_q[6:0], sda_s};
            bcnt_q <= bcnt_q + 4'h1;
            if (i_q == I_PARM && bcnt_q == 4'h0) begin
              v_q <= sda_s; // R7
            end
          end
          if (scl_fall && !ack_ph_q && bcnt_q == 4'h8) begin
            ack_ph_q <= 1'b1;
            sda_oe <= 1'b0;
            nxt_q <= I_IGN;
            case (i_q)
              I_ADDR: begin
                if (shf_q[7:1] == `SWB_I2C_ADDR && !shf_q[0]) begin
                  sda_oe <= 1'b1;
                  nxt_q <= I_CMD;
                end
              end
              I_CMD: begin
                if (shf_q == `SWB_CMD_RESET && !busy_q) begin // R1 R2
                  sda_oe <= 1'b1;
                  pend_rst_q <= 1'b1;
                end else if (shf_q == `SWB_CMD_SLOT && !busy_q) begin // R10
                  sda_oe <= 1'b1;
                  nxt_q <= I_PARM;
                end
              end
              default: begin
                sda_oe <= 1'b1;
              end
            endcase
          end else if (scl_fall && ack_ph_q) begin
            ack_ph_q <= 1'b0;
            sda_oe <= 1'b0;
            bcnt_q <= 4'h0;
            pend_rst_q <= 1'b0;
            i_q <= nxt_q;
          end
        end
        default: begin
          i_q <= I_IDLE;
        end
      endcase
    end
  end

  assign rej_ev = scl_fall && !ack_ph_q && bcnt_q == 4'h8 && i_q == I_CMD
                  && busy_q && (shf_q == `SWB_CMD_RESET
                  || shf_q == `SWB_CMD_SLOT);

  // sample instants, compared against the tick count about to be reached
  assign ev_si = tick && w_q == W_RHIGH && t_q + 12'd1
                 == spd(cfg_q[`SWB_C_ODS], `SWB_SI_STD, `SWB_SI_OVD);
  assign ev_msp = tick && w_q == W_RHIGH && t_q + 12'd1
                  == spd(cfg_q[`SWB_C_ODS], `SWB_MSP_STD, `SWB_MSP_OVD);
  assign ev_msr = tick && (w_q == W_SLOW || w_q == W_SREC) && t_q + 12'd1
                  == spd(cfg_q[`SWB_C_ODS], `SWB_MSR_STD, `SWB_MSR_OVD);
  assign rst_end = tick && w_q == W_RHIGH && t_q + 12'd1
                   == spd(cfg_q[`SWB_C_ODS], `SWB_RSTH_STD, `SWB_RSTH_OVD);
  assign slot_end = tick && (w_q == W_SLOW || w_q == W_SREC) && t_q + 12'd1
                    == spd(cfg_q[`SWB_C_ODS], `SWB_SLOT_STD, `SWB_SLOT_OVD);
  assign low_end = tick && t_q + 12'd1 == (w_q == W_RLOW
                   ? spd(cfg_q[`SWB_C_ODS], `SWB_RSTL_STD, `SWB_RSTL_OVD)
                   : v_q ? spd(cfg_q[`SWB_C_ODS], `SWB_W1L_STD, `SWB_W1L_OVD)
                   : spd(cfg_q[`SWB_C_ODS], `SWB_W0L_STD, `SWB_W0L_OVD));

  // line sequencer; overdrive is sampled at every comparison
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      w_q <= W_IDLE;
      t_q <= 12'h000;
      ow_oe <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      case (w_q)
        W_IDLE: begin
          t_q <= 12'h000;
          if (go_rst) begin
            w_q <= W_RLOW;
            ow_oe <= 1'b1; // R1
            busy_q <= 1'b1; // R4
          end else if (go_slot) begin
            w_q <= W_SLOW;
            ow_oe <= 1'b1; // R8
            busy_q <= 1'b1; // R12
          end
        end
        W_RLOW: begin
          if (low_end) begin
            w_q <= W_RHIGH;
            ow_oe <= 1'b0;
            t_q <= 12'h000;
          end else if (tick) begin
            t_q <= t_q + 12'd1;
          end
        end
        W_RHIGH: begin
          if (rst_end) begin
            w_q <= W_IDLE;
            busy_q <= 1'b0; // R4
          end else if (tick) begin
            t_q <= t_q + 12'd1;
          end
        end
        W_SLOW, W_SREC: begin
          if (slot_end) begin
            w_q <= W_IDLE;
            ow_oe <= 1'b0;
            busy_q <= 1'b0; // R12
          end else begin
            if (w_q == W_SLOW && low_end) begin
              w_q <= W_SREC;
              ow_oe <= 1'b0; // R8
            end
            if (tick) begin
              t_q <= t_q + 12'd1;
            end
          end
        end
        default: begin
          w_q <= W_IDLE;
          ow_oe <= 1'b0;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  // result flags, each written at its own sample instant
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ppd_q <= 1'b0;
      sd_q <= 1'b0;
      sbr_q <= 1'b0;
    end else begin
      if (ev_si) begin
        sd_q <= !ow_s; // R5
      end
      if (ev_msp) begin
        ppd_q <= !ow_s; // R5
      end
      if (ev_msr) begin
        sbr_q <= ow_s; // R9
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ptr_q <= `SWB_PTR_STATUS;
    end else if (go_rst || go_slot) begin
      ptr_q <= `SWB_PTR_STATUS; // R6 R13
    end
  end

  // pullups: active only while released, strong held after a slot
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ow_apu <= 1'b0;
      ow_spu <= 1'b0;
    end else begin
      ow_apu <= cfg_q[`SWB_C_APU] && !ow_oe
                && (w_q == W_RHIGH || w_q == W_SREC); // R14
      if (go_rst || go_slot || reg_wr) begin
        ow_spu <= 1'b0;
      end else if (slot_end && cfg_q[`SWB_C_SPU]) begin
        ow_spu <= 1'b1; // R14
      end
    end
  end

  assign ev = {rej_ev, ev_si && !ow_s, ev_msp && !ow_s, rst_end || slot_end};

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cfg_q <= 4'h0;
      imask_q <= 4'h0;
    end else if (reg_wr && reg_addr == `SWB_A_CFG) begin
      cfg_q <= reg_wdata[3:0];
    end else if (reg_wr && reg_addr == `SWB_A_IMASK) begin
      imask_q <= reg_wdata[3:0];
    end else if (slot_end && cfg_q[`SWB_C_SPU]) begin
      cfg_q[`SWB_C_SPU] <= 1'b0;
    end
  end

  // new events win over a write-one clear in the same cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ist_q <= 4'h0;
    end else if (reg_wr && reg_addr == `SWB_A_ISTAT) begin
      ist_q <= (ist_q & ~reg_wdata[3:0]) | ev;
    end else begin
      ist_q <= ist_q | ev;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
      irq <= 1'b0;
      sda_out <= 1'b0;
      ow_out <= 1'b0;
    end else begin
      irq <= |(ist_q & imask_q);
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `SWB_A_CFG: reg_rdata <= {4'h0, cfg_q};
          `SWB_A_STAT: reg_rdata <= {4'h0, sbr_q, sd_q, ppd_q, busy_q};
          `SWB_A_ISTAT: reg_rdata <= {4'h0, ist_q};
          `SWB_A_IMASK: reg_rdata <= {4'h0, imask_q};
          `SWB_A_PTR: reg_rdata <= ptr_q;
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  logic [19:0] busy_len_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      busy_len_q <= 20'h0;
    end else if (go_rst || go_slot) begin
      busy_len_q <= 20'h0;
    end else if (busy_q) begin
      busy_len_q <= busy_len_q + 20'h1;
    end
  end
  logic was_rst_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      was_rst_q <= 1'b0;
    end else if (go_rst || go_slot) begin
      was_rst_q <= go_rst;
    end
  end

  sequence s_code_busy;
    scl_fall && !ack_ph_q && bcnt_q == 4'h8 && i_q == I_CMD && busy_q;
  endsequence

  chk_reset_start: assert property (scl_fall && ack_ph_q && pend_rst_q // R3
    |=> ow_oe && busy_q && w_q == W_RLOW)
    else $error("reset did not start in time");
  chk_slot_start: assert property (go_slot |=> ow_oe && busy_q // R11
    && w_q == W_SLOW)
    else $error("slot did not start");
  chk_busy_nack: assert property (s_code_busy |=> !sda_oe[*2]) // R2
    else $error("code acked while busy");
  chk_busy_noparm: assert property (s_code_busy // R10
    |=> nxt_q == I_IGN && !pend_rst_q)
    else $error("busy command not ignored");
  chk_rst_len: assert property ($fell(busy_q) && was_rst_q |->
    busy_len_q == 20'(`SWB_TICK_CYC) * 20'(32'(spd(cfg_q[`SWB_C_ODS],
    `SWB_RSTL_STD, `SWB_RSTL_OVD)) + 32'(spd(cfg_q[`SWB_C_ODS],
    `SWB_RSTH_STD, `SWB_RSTH_OVD)))) // R4
    else $error("reset busy length wrong");
  chk_slot_len: assert property ($fell(busy_q) && !was_rst_q |->
    busy_len_q == 20'(`SWB_TICK_CYC) * spd(cfg_q[`SWB_C_ODS],
    `SWB_SLOT_STD, `SWB_SLOT_OVD)) // R12
    else $error("slot busy length wrong");
  chk_flag_samp: assert property (ev_msp |=> ppd_q == !$past(ow_s)) // R5
    else $error("presence flag not updated");
  chk_sbr_samp: assert property (ev_msr |=> sbr_q == $past(ow_s)) // R9
    else $error("bit result not updated");
  chk_ptr_status: assert property ((go_rst || go_slot) // R6
    |=> ptr_q == `SWB_PTR_STATUS)
    else $error("read pointer not on status");
  chk_zero_low: assert property (w_q == W_SREC |-> v_q // R8
    || t_q >= spd(cfg_q[`SWB_C_ODS], `SWB_W0L_STD, `SWB_W0L_OVD) - 12'd1)
    else $error("write-zero released early");
  chk_apu_gate: assert property (ow_apu |-> $past(cfg_q[`SWB_C_APU])) // R14
    else $error("active pullup without enable");
endmodule

// [testbench/swb_wire_slave.sv]
// single-wire slave model: presence, short and read-zero answers
`timescale 1ns/1ns
module swb_wire_slave #(
  parameter int RST_MIN = 5000,
  parameter int PD_WAIT = 375,
  parameter int PD_LEN = 1250,
  parameter int RD_HOLD = 500
) (
  input wire logic mclk,
  input wire logic line,
  input wire logic present,
  input wire logic short_on,
  input wire logic read_bit,
  output logic pull
);
  logic l_d = 1'b1;
  int low_n = 0;
  int wait_n = 0;
  int pd_n = 0;
  int rd_n = 0;
  // the line has a pull-up, so a released line is simply not pulled
  assign pull = short_on | (rd_n > 0) | (pd_n > 0);
  always @(posedge mclk) begin
    l_d <= line;
    // a shorted line is no master reset, so it earns no presence answer
    low_n <= (line || short_on) ? 0 : low_n + 1;
    // a long low is a bus reset: answer with a presence pulse
    if (line && !l_d && low_n >= RST_MIN && present)
      wait_n <= PD_WAIT;
    else if (wait_n > 0)
      wait_n <= wait_n - 1;
    if (wait_n == 1)
      pd_n <= PD_LEN;
    else if (pd_n > 0)
      pd_n <= pd_n - 1;
    // reading a zero: hold the slot low past the sample point
    if (!line && l_d && !read_bit)
      rd_n <= RD_HOLD;
    else if (rd_n > 0)
      rd_n <= rd_n - 1;
  end
endmodule

// [testbench/swb_top_test.sv]
// self-checking bench for the single-wire command sequencer
`timescale 1ns/1ns
`include "swb_cfg.svh"
module swb_top_test;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic scl = 1'b1;
  logic host_low = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata, d;
  logic sda_out, sda_oe, ow_out, ow_oe, ow_apu, ow_spu, irq, slv_pull;
  logic present = 1'b1;
  logic short_on = 1'b0;
  logic read_bit = 1'b1;
  logic oe_d = 1'b0;
  logic ak1, ak2;
  wire sda_line = ~(sda_oe | host_low);
  wire ow_line = ~(ow_oe | slv_pull);
  int cyc = 0, t_act = 0, t_rel = 0, fa = 0, fm = 0, blen = 0, apu_n = 0;
  int bad_count = 0, checked = 0;

  always #4 mclk = ~mclk;

  swb_top dut (.mclk(mclk), .nrst(nrst), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .ow_in(ow_line), .ow_out(ow_out),
    .ow_oe(ow_oe), .ow_apu(ow_apu), .ow_spu(ow_spu), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq));
  swb_wire_slave slv (.mclk(mclk), .line(ow_line), .present(present),
    .short_on(short_on), .read_bit(read_bit), .pull(slv_pull));

  // edge times of the line drive, in clock cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    oe_d <= ow_oe;
    if (ow_oe && !oe_d) t_act <= cyc;
    if (!ow_oe && oe_d) t_rel <= cyc;
    if (ow_apu) apu_n <= apu_n + 1;
  end

  task check(input string name, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // 80 ns scl period; sda moves mid-low, ack sampled mid-high
  task i2c_byte(input logic [7:0] v, output logic ack, output int t_msb,
      output int t_ack);
    for (int i = 8; i >= 0; i--) begin
      @(posedge mclk);
      scl <= 1'b0;
      if (i == 7) t_msb = cyc;
      if (i == 0) t_ack = cyc;
      repeat (2) @(posedge mclk);
      host_low <= (i > 0) ? ~v[i-1] : 1'b0;
      repeat (3) @(posedge mclk);
      scl <= 1'b1;
      repeat (2) @(posedge mclk);
      ack = (sda_line === 1'b0);
      repeat (2) @(posedge mclk);
    end
  endtask

  task cmd(input logic [7:0] c, input bit two, input logic [7:0] p,
      output logic a1, a2);
    int tx;
    a2 = 1'b0;
    @(posedge mclk);
    host_low <= 1'b1;
    repeat (4) @(posedge mclk);
    i2c_byte({`SWB_I2C_ADDR, 1'b0}, a1, tx, tx);
    i2c_byte(c, a1, tx, tx);
    if (two) i2c_byte(p, a2, fm, tx);
    @(posedge mclk);
    scl <= 1'b0;
    // for a reset this fall ends the code ack and launches the line
    fa = cyc;
    repeat (2) @(posedge mclk);
    host_low <= 1'b1;
    repeat (3) @(posedge mclk);
    scl <= 1'b1;
    repeat (3) @(posedge mclk);
    host_low <= 1'b0;
    repeat (5) @(posedge mclk);
  endtask

  // back-to-back status reads; counts cycles with busy seen
  task poll(output int n);
    bit seen;
    n = 0;
    seen = 0;
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= `SWB_A_STAT;
    for (int k = 0; k < 40000; k++) begin
      @(posedge mclk);
      #1;
      if (reg_rdata[`SWB_S_BUSY] === 1'b1) begin
        seen = 1;
        n++;
      end else if (seen) break;
    end
    reg_rd <= 1'b0;
  endtask

  task t_reset(input bit sh);
    short_on <= sh;
    fork
      cmd(`SWB_CMD_RESET, 0, 8'h00, ak1, ak2);
      poll(blen);
    join
    short_on <= 1'b0;
    check("reset ack", ak1, 1);
    check("reset start", (t_act - fa) <= `SWB_START_MAX_CYC, 1);
    check("reset low", t_rel - t_act, `SWB_RSTL_OVD * `SWB_TICK_CYC);
    check("reset busy", blen,
      (`SWB_RSTL_OVD + `SWB_RSTH_OVD) * `SWB_TICK_CYC);
    rd(`SWB_A_STAT, d);
    check("presence", d[`SWB_S_PPD], 1);
    check("short", d[`SWB_S_SD], sh);
    rd(`SWB_A_PTR, d);
    check("reset pointer", d, `SWB_PTR_STATUS);
    $display("test reset short=%0d done", sh);
  endtask

  task t_slot(input logic [7:0] cfg, p, input logic rb, input int lo);
    int a0;
    wr(`SWB_A_CFG, cfg);
    a0 = apu_n;
    read_bit <= rb;
    fork
      cmd(`SWB_CMD_SLOT, 1, p, ak1, ak2);
      poll(blen);
    join
    check("slot acks", {ak1, ak2}, 2'b11);
    check("slot start", (t_act - fm) <= `SWB_START_MAX_CYC, 1);
    check("slot low", t_rel - t_act, lo * `SWB_TICK_CYC);
    check("slot busy", blen, `SWB_SLOT_OVD * `SWB_TICK_CYC);
    rd(`SWB_A_STAT, d);
    check("bit result", d[`SWB_S_SBR], p[7] & rb);
    rd(`SWB_A_PTR, d);
    check("slot pointer", d, `SWB_PTR_STATUS);
    check("strong pullup", ow_spu, cfg[`SWB_C_SPU]);
    check("active pullup", apu_n != a0, cfg[`SWB_C_APU]);
    $display("test slot %h done", p);
  endtask

  task t_reject();
    wr(`SWB_A_IMASK, 8'h08);
    cmd(`SWB_CMD_RESET, 0, 8'h00, ak1, ak2);
    cmd(`SWB_CMD_RESET, 0, 8'h00, ak1, ak2);
    check("busy reset nack", ak1, 0);
    cmd(`SWB_CMD_SLOT, 1, 8'h80, ak1, ak2);
    check("busy slot nack", {ak1, ak2}, 2'b00);
    poll(blen);
    check("irq raised", irq, 1);
    check("open drain data", {sda_out, ow_out}, 2'b00);
    wr(`SWB_A_IMASK, 8'h00);
    repeat (2) @(posedge mclk);
    #1 check("irq masked", irq, 0);
    wr(`SWB_A_IMASK, 8'h08);
    wr(`SWB_A_ISTAT, 8'h0f);
    repeat (2) @(posedge mclk);
    #1 check("irq cleared", irq, 0);
    rd(`SWB_A_ISTAT, d);
    check("reject flag", d[`SWB_I_REJ], 0);
    rd(4'hf, d);
    check("unmapped read", d, 8'h00);
    $display("test reject done");
  endtask

  task complete_run();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // the tests need about 61000 cycles
  initial begin
    repeat (90000) @(posedge mclk);
    bad_count++;
    $display("watchdog expired");
    complete_run();
  end

  initial begin
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    // overdrive keeps the reset cycle short enough to simulate
    wr(`SWB_A_CFG, 8'h09);
    t_reset(1'b0);
    t_reset(1'b1);
    t_slot(8'h09, 8'h80, 1'b1, `SWB_W1L_OVD);
    t_slot(8'h09, 8'h7f, 1'b1, `SWB_W0L_OVD);
    t_slot(8'h0d, 8'hff, 1'b0, `SWB_W1L_OVD);
    t_slot(8'h08, 8'h80, 1'b1, `SWB_W1L_OVD);
    t_reject();
    complete_run();
  end
endmodule
